// ===== rchs_pkg.sv
// Package for the receive channel hop sequencer: property numbers, field
// layouts, timing constants and the command and state encodings.
// Assumes a single 40 MHz clock shared by both ends of the command link.
//
// What this block does
// R01: Synth word is integer plus fraction over 2^19
// R02: Host keeps fraction between one and two
// R03: Frequency equals base plus channel times step
// R04: Host loads step as high and low bytes
// R05: Start channel argument optional, previous kept, zero initially
// R06: Hop table of 64, size setting limits use
// R07: Auto hopping starts on entering receive
// R08: Entries visited in order, wrapping to first
// R09: Entries holding 0xFF are skipped
// R10: Hop conditions enabled singly or together, first wins
// R11: Instantaneous strength above threshold stays, below hops
// R12: Raw mode allows only strength condition
// R13: Automatic hop completes within 115 us
// R14: Manual hop retunes in 75 us with host calibration
// R15: Optional output toggles on hop and wrap
// R16: Host starts receive on first non-0xFF entry
// R17: Transmit modulation added through fractional word
// R18: External ramp off until type bit 7 set
// R19: Internal and external ramps start together
// R20: Four-bit ramp code selects 1.25 to 20 us
// R21: Fine power level offers 128 steps
// R22: Last channel held for reuse
package rchs_pkg;

  // ----------
  // Clock and timing
  // ----------
  localparam int CLK_MHZ          = 40;
  localparam int AUTO_HOP_TIME_NS = 115000;
  localparam int MAN_HOP_TIME_NS  = 75000;
  localparam int AUTO_HOP_CYC     = AUTO_HOP_TIME_NS * CLK_MHZ / 1000;
  localparam int MAN_HOP_CYC      = MAN_HOP_TIME_NS * CLK_MHZ / 1000;
  localparam int CNT_W            = 16;

  // ----------
  // Widths and table
  // ----------
  localparam int FRAC_BITS   = 19;
  localparam int SYNTH_W     = 28;
  localparam int HOP_DEPTH   = 64;
  localparam int IDX_W       = 6;
  localparam logic [7:0] SKIP_ENTRY = 8'hFF;
  localparam logic [7:0] CHAN_INIT  = 8'h00;

  // ----------
  // Property numbers
  // ----------
  localparam logic [15:0] P_INTE       = 16'h4000;
  localparam logic [15:0] P_FRAC_HIGH  = 16'h4001;
  localparam logic [15:0] P_FRAC_MID   = 16'h4002;
  localparam logic [15:0] P_FRAC_LOW   = 16'h4003;
  localparam logic [15:0] P_STEP_HIGH  = 16'h4004;
  localparam logic [15:0] P_STEP_LOW   = 16'h4005;
  localparam logic [15:0] P_RSSI_THR   = 16'h200A;
  localparam logic [15:0] P_HOP_SIZE   = 16'h5000;
  localparam logic [15:0] P_HOP_CTRL   = 16'h5001;
  localparam logic [15:0] P_HOP_ENTRY  = 16'h5002;
  localparam logic [15:0] P_AMP_TYPE   = 16'h2200;
  localparam logic [15:0] P_PWR_FINE   = 16'h2201;
  localparam logic [15:0] P_PWR_COARSE = 16'h2202;
  localparam logic [15:0] P_RAMP_TIME  = 16'h2203;

  // Hop control bits and other property field bit positions
  localparam int HC_RSSI = 0;
  localparam int HC_PRE  = 1;
  localparam int HC_SYNC = 2;
  localparam int HC_AUTO = 3;
  localparam int HC_GPIO = 4;
  localparam int HC_RAW  = 5;
  localparam int AMP_EXT_RAMP = 7;
  localparam int FRAC_ONE_BIT = 3;  // Bit 19 of the word, inside high byte
  localparam logic [6:0] PWR_FINE_MASK = 7'h7F;

  // ----------
  // Host APB map
  // ----------
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_PROP   = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;

  typedef enum logic [2:0] {
    RCHS_OP_NONE, RCHS_OP_SET_PROP, RCHS_OP_START_RX, RCHS_OP_START_TX,
    RCHS_OP_RX_HOP, RCHS_OP_STOP
  } rchs_op_t;

  typedef enum logic [2:0] {
    RCHS_IDLE, RCHS_RX, RCHS_SEEK, RCHS_SETTLE, RCHS_TX_UP, RCHS_TX_ON,
    RCHS_TX_DOWN
  } rchs_state_t;

  // Ramp duration for each time-constant code, in ns
  localparam int RAMP_NS [16] = '{1250, 1330, 1430, 1540, 1670, 1820, 2000,
    2220, 2500, 2860, 3330, 4000, 5000, 6670, 10000, 20000};

  // Each ramp time rounds up to whole cycles
  function automatic logic [CNT_W-1:0] ramp_cyc(input logic [3:0] tc);
    ramp_cyc = CNT_W'((RAMP_NS[tc] * CLK_MHZ + 999) / 1000);
  endfunction

endpackage

// ===== rchs_if.sv
// Command link between the host controller and the hop sequencer.
// Assumes both ends share one clock; the testbench instantiates it.
`timescale 1ns/1ps
interface rchs_if;
  import rchs_pkg::*;

  logic        cmd_valid;
  logic        cmd_ready;
  rchs_op_t    cmd_op;
  logic [15:0] cmd_prop;
  logic [7:0]  cmd_data;
  logic        cmd_has_chan;
  logic [7:0]  cmd_chan;
  logic [15:0] cmd_calib;
  rchs_state_t st_state;
  logic [7:0]  st_chan;

  modport host (output cmd_valid, cmd_op, cmd_prop, cmd_data, cmd_has_chan,
                cmd_chan, cmd_calib,
                input  cmd_ready, st_state, st_chan);
  modport dev  (input  cmd_valid, cmd_op, cmd_prop, cmd_data, cmd_has_chan,
                cmd_chan, cmd_calib,
                output cmd_ready, st_state, st_chan);
endinterface

// ===== rchs_dev.sv
// Hop sequencer device end: property store, hop table, auto and manual
// hopping, synthesizer word and amplifier ramp control.
// Assumes modem inputs (strength, timeouts, modulation) are synchronous.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rchs_dev #(
  parameter int AUTO_HOP_CYCLES = rchs_pkg::AUTO_HOP_CYC
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_ce,
  rchs_if.dev                             link,
  input  wire logic [7:0]                 i_rssi,
  input  wire logic                       i_preamble_timeout,
  input  wire logic                       i_sync_timeout,
  input  wire logic signed [15:0]         i_tx_mod,
  output logic [rchs_pkg::SYNTH_W-1:0]    o_synth_word,
  output logic [15:0]                     o_calib_count,
  output logic                            o_hop_gpio,
  output logic                            o_pa_on,
  output logic                            o_pa_ramping,
  output logic                            o_ext_ramp_on,
  output logic                            o_ext_ramp_ramping,
  output logic [6:0]                      o_pwr_fine,
  output logic [7:0]                      o_pwr_coarse
);
  import rchs_pkg::*;

  // ----------
  // State
  // ----------
  rchs_state_t        state_q, state_d;
  logic [7:0]         inte_q, inte_d, fh_q, fh_d, fm_q, fm_d, fl_q, fl_d;
  logic [7:0]         sh_q, sh_d, sl_q, sl_d, thr_q, thr_d;
  logic [7:0]         size_q, size_d, ctrl_q, ctrl_d;
  logic [7:0]         amp_q, amp_d, pwr_q, pwr_d, bias_q, bias_d;
  logic [7:0]         rt_q, rt_d, chan_q, chan_d;
  logic [IDX_W-1:0]   idx_q, idx_d;
  logic [IDX_W:0]     tries_q, tries_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [15:0]        calib_q, calib_d;
  logic               stay_q, stay_d, gpio_q, gpio_d;
  logic [SYNTH_W-1:0] word_q, word_d;
  logic [7:0]         table_q [HOP_DEPTH];
  logic               tbl_we;
  logic               take, hop_req;
  logic [IDX_W-1:0]   idx_nx, last_idx;

  // Base plus channel times step, all in fractional units
  function automatic logic [SYNTH_W-1:0] freq_word(
      input logic [7:0] inte, input logic [19:0] frac,
      input logic [7:0] chan, input logic [15:0] step);
    freq_word = SYNTH_W'({inte, {FRAC_BITS{1'b0}}}) + SYNTH_W'(frac)
              + SYNTH_W'(chan * step);  // see R01 see R03
  endfunction

  // Table index after idx, wrapping at the programmed size
  function automatic logic [IDX_W-1:0] next_idx(
      input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] last);
    next_idx = (idx >= last) ? '0 : idx + 1'b1;  // see R06 see R08
  endfunction

  assign take     = link.cmd_valid & link.cmd_ready;
  assign last_idx = (size_q == 8'h00) ? '0
                  : (size_q > 8'(HOP_DEPTH)) ? IDX_W'(HOP_DEPTH - 1)
                  : IDX_W'(size_q - 8'h01);
  assign idx_nx   = next_idx(idx_q, last_idx);
  assign tbl_we   = take & (link.cmd_op == RCHS_OP_SET_PROP)
                  & (link.cmd_prop >= P_HOP_ENTRY)
                  & (link.cmd_prop < P_HOP_ENTRY + 16'(HOP_DEPTH));

  // Hop decision: first enabled condition met decides; raw mode only
  // permits the strength test since timeouts need packet handling
  always_comb begin
    hop_req = 1'b0;
    if (ctrl_q[HC_RSSI] && i_rssi < thr_q) begin
      hop_req = 1'b1;                                  // see R11
    end
    if (!ctrl_q[HC_RAW] && ctrl_q[HC_PRE] && i_preamble_timeout) begin
      hop_req = 1'b1;                                  // see R10 see R12
    end
    if (!ctrl_q[HC_RAW] && ctrl_q[HC_SYNC] && i_sync_timeout) begin
      hop_req = 1'b1;                                  // see R10 see R12
    end
  end

  // ----------
  // Next-state logic
  // ----------
  always_comb begin
    state_d = state_q;  inte_d = inte_q;  fh_d = fh_q;  fm_d = fm_q;
    fl_d = fl_q;  sh_d = sh_q;  sl_d = sl_q;  thr_d = thr_q;
    size_d = size_q;  ctrl_d = ctrl_q;  amp_d = amp_q;  pwr_d = pwr_q;
    bias_d = bias_q;  rt_d = rt_q;  chan_d = chan_q;  idx_d = idx_q;
    tries_d = tries_q;  cnt_d = cnt_q;  calib_d = calib_q;
    stay_d = stay_q;  gpio_d = gpio_q;
    if (take && link.cmd_op == RCHS_OP_SET_PROP) begin
      case (link.cmd_prop)
        P_INTE:       inte_d = link.cmd_data;
        P_FRAC_HIGH:  fh_d   = link.cmd_data;
        P_FRAC_MID:   fm_d   = link.cmd_data;
        P_FRAC_LOW:   fl_d   = link.cmd_data;
        P_STEP_HIGH:  sh_d   = link.cmd_data;
        P_STEP_LOW:   sl_d   = link.cmd_data;
        P_RSSI_THR:   thr_d  = link.cmd_data;
        P_HOP_SIZE:   size_d = link.cmd_data;  // see R06
        P_HOP_CTRL:   ctrl_d = link.cmd_data;
        P_AMP_TYPE:   amp_d  = link.cmd_data;  // see R18
        P_PWR_FINE:   pwr_d  = link.cmd_data;  // see R21
        P_PWR_COARSE: bias_d = link.cmd_data;
        P_RAMP_TIME:  rt_d   = link.cmd_data;
        default: ;
      endcase
    end
    case (state_q)
      RCHS_IDLE, RCHS_RX, RCHS_TX_ON: begin
        if (take && link.cmd_op == RCHS_OP_START_RX) begin
          if (link.cmd_has_chan) begin
            chan_d = link.cmd_chan;            // see R05 see R22
          end
          state_d = RCHS_RX;                   // see R07
          idx_d   = '0;
          stay_d  = 1'b0;
        end else if (take && link.cmd_op == RCHS_OP_START_TX) begin
          if (link.cmd_has_chan) begin
            chan_d = link.cmd_chan;            // see R05 see R22
          end
          state_d = RCHS_TX_UP;
          cnt_d   = ramp_cyc(rt_q[3:0]);       // see R20
        end else if (take && link.cmd_op == RCHS_OP_RX_HOP) begin
          chan_d  = link.cmd_chan;
          calib_d = link.cmd_calib;            // see R14
          state_d = RCHS_SETTLE;
          cnt_d   = CNT_W'(MAN_HOP_CYC);       // see R14
        end else if (take && link.cmd_op == RCHS_OP_STOP) begin
          if (state_q == RCHS_TX_ON) begin
            state_d = RCHS_TX_DOWN;            // see R19
            cnt_d   = ramp_cyc(rt_q[3:0]);
          end else begin
            state_d = RCHS_IDLE;
          end
        end else if (state_q == RCHS_RX && ctrl_q[HC_AUTO] && !stay_q) begin
          if (ctrl_q[HC_RSSI] && i_rssi > thr_q) begin
            stay_d = 1'b1;                     // see R11
          end else if (hop_req) begin
            state_d = RCHS_SEEK;               // see R07
            tries_d = '0;
          end
        end
      end
      RCHS_SEEK: begin
        // One entry a cycle; a table that is all skips leaves us put
        idx_d   = idx_nx;                      // see R08
        tries_d = tries_q + 1'b1;
        if (idx_nx == '0 && ctrl_q[HC_GPIO]) begin
          gpio_d = ~gpio_q;                    // see R15
        end
        if (table_q[idx_nx] != SKIP_ENTRY) begin  // see R09
          chan_d  = table_q[idx_nx];
          state_d = RCHS_SETTLE;
          cnt_d   = CNT_W'(AUTO_HOP_CYCLES - 1 - int'(tries_q));  // see R13
          if (ctrl_q[HC_GPIO]) begin
            gpio_d = (idx_nx == '0) ? gpio_q : ~gpio_q;  // see R15
          end
        end else if (tries_q > {1'b0, last_idx}) begin
          state_d = RCHS_RX;
          stay_d  = 1'b1;
        end
      end
      RCHS_SETTLE: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q <= CNT_W'(1)) begin
          state_d = RCHS_RX;
          stay_d  = 1'b0;
        end
      end
      RCHS_TX_UP, RCHS_TX_DOWN: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q <= CNT_W'(1)) begin
          state_d = (state_q == RCHS_TX_UP) ? RCHS_TX_ON : RCHS_IDLE;
        end
      end
      default: state_d = RCHS_IDLE;
    endcase
    word_d = freq_word(inte_q, {fh_q[3:0], fm_q, fl_q}, chan_d,
                       {sh_q, sl_q});
    if (state_d == RCHS_TX_UP || state_d == RCHS_TX_ON
        || state_d == RCHS_TX_DOWN) begin
      word_d = word_d + SYNTH_W'(signed'(i_tx_mod));  // see R17
    end
  end

  // ----------
  // Registers
  // ----------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= RCHS_IDLE;  inte_q <= '0;  fh_q <= '0;  fm_q <= '0;
      fl_q <= '0;  sh_q <= '0;  sl_q <= '0;  thr_q <= '0;  size_q <= '0;
      ctrl_q <= '0;  amp_q <= '0;  pwr_q <= '0;  bias_q <= '0;
      rt_q <= '0;  chan_q <= CHAN_INIT;  idx_q <= '0;  tries_q <= '0;
      cnt_q <= '0;  calib_q <= '0;  stay_q <= 1'b0;  gpio_q <= 1'b0;
      word_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;  inte_q <= inte_d;  fh_q <= fh_d;  fm_q <= fm_d;
      fl_q <= fl_d;  sh_q <= sh_d;  sl_q <= sl_d;  thr_q <= thr_d;
      size_q <= size_d;  ctrl_q <= ctrl_d;  amp_q <= amp_d;
      pwr_q <= pwr_d;  bias_q <= bias_d;  rt_q <= rt_d;  chan_q <= chan_d;
      idx_q <= idx_d;  tries_q <= tries_d;  cnt_q <= cnt_d;
      calib_q <= calib_d;  stay_q <= stay_d;  gpio_q <= gpio_d;
      word_q <= word_d;
    end
  end

  // Hop table store; no reset, software fills it before use
  always_ff @(posedge i_mclk) begin
    if (i_ce && tbl_we) begin
      table_q[IDX_W'(link.cmd_prop - P_HOP_ENTRY)] <= link.cmd_data;
    end
  end

  // ----------
  // Outputs
  // ----------
  // Busy while seeking or settling so a hop is never cut short
  assign link.cmd_ready  = (state_q != RCHS_SEEK) && (state_q != RCHS_SETTLE)
                        && (state_q != RCHS_TX_UP)
                        && (state_q != RCHS_TX_DOWN);
  assign link.st_state   = state_q;
  assign link.st_chan    = chan_q;
  assign o_synth_word    = word_q;
  assign o_calib_count   = calib_q;
  assign o_hop_gpio      = gpio_q;
  assign o_pa_on         = (state_q == RCHS_TX_UP) || (state_q == RCHS_TX_ON)
                        || (state_q == RCHS_TX_DOWN);
  assign o_pa_ramping    = (state_q == RCHS_TX_UP)
                        || (state_q == RCHS_TX_DOWN);
  assign o_ext_ramp_on      = o_pa_on & amp_q[AMP_EXT_RAMP];  // see R18 R19
  assign o_ext_ramp_ramping = o_pa_ramping & amp_q[AMP_EXT_RAMP];  // see R19
  assign o_pwr_fine      = pwr_q[6:0] & PWR_FINE_MASK;          // see R21
  assign o_pwr_coarse    = bias_q;

endmodule // rchs_dev

// ===== rchs_host.sv
// Host controller end: APB slave registers that turn software writes
// into commands on the link and report the device state back.
// Assumes an APB master on the same clock; pready is always high.
`timescale 1ns/1ps
module rchs_host (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  rchs_if.host             link
);
  import rchs_pkg::*;

  // ----------
  // State
  // ----------
  logic        pend_q, pend_d, shi_q, shi_d, slo_q, slo_d, bad_q, bad_d;
  rchs_op_t    op_q, op_d;
  logic        hc_q, hc_d;
  logic [7:0]  ch_q, ch_d, data_q, data_d;
  logic [15:0] cal_q, cal_d, prop_q, prop_d;
  logic [31:0] rd_q, rd_d;
  logic        acc, wr, mapped;

  assign acc    = i_psel & i_penable;
  assign wr     = acc & i_pwrite;
  assign mapped = (i_paddr == A_CMD) || (i_paddr == A_PROP)
               || (i_paddr == A_STATUS);

  // Command launch holds until the device takes it; command and property
  // writes that land while a command is pending are dropped rather than queued
  always_comb begin
    pend_d = pend_q;  shi_d = shi_q;  slo_d = slo_q;  bad_d = bad_q;
    op_d = op_q;  hc_d = hc_q;  ch_d = ch_q;  cal_d = cal_q;
    prop_d = prop_q;  data_d = data_q;  rd_d = rd_q;
    if (pend_q && link.cmd_ready) begin
      pend_d = 1'b0;
      if (op_q == RCHS_OP_SET_PROP && prop_q == P_STEP_HIGH) begin
        shi_d = 1'b1;                                 // see R04
      end
      if (op_q == RCHS_OP_SET_PROP && prop_q == P_STEP_LOW) begin
        slo_d = 1'b1;                                 // see R04
      end
    end
    if (wr && !pend_q && i_paddr == A_PROP) begin
      prop_d = i_pwdata[15:0];
      data_d = i_pwdata[23:16];
    end
    if (wr && !pend_q && i_paddr == A_CMD) begin
      op_d  = rchs_op_t'(i_pwdata[2:0]);
      hc_d  = i_pwdata[3];
      ch_d  = i_pwdata[15:8];   // First non-skip entry for hopping, see R16
      cal_d = i_pwdata[31:16];  // see R14
      pend_d = 1'b1;
      // Fraction below one is refused and flagged
      if (rchs_op_t'(i_pwdata[2:0]) == RCHS_OP_SET_PROP
          && prop_q == P_FRAC_HIGH && !data_q[FRAC_ONE_BIT]) begin
        pend_d = 1'b0;                                // see R02
        bad_d  = 1'b1;
      end
      // Start with a channel needs both step bytes first
      if ((rchs_op_t'(i_pwdata[2:0]) == RCHS_OP_START_RX
           || rchs_op_t'(i_pwdata[2:0]) == RCHS_OP_START_TX)
          && i_pwdata[3] && !(shi_q && slo_q)) begin
        pend_d = 1'b0;                                // see R04
        bad_d  = 1'b1;
      end
    end
    if (wr && i_paddr == A_STATUS) begin
      bad_d = 1'b0;
    end
    rd_d = '0;
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        A_CMD:    rd_d = {cal_q, ch_q, 4'h0, hc_q, op_q};
        A_PROP:   rd_d = {8'h00, data_q, prop_q};
        A_STATUS: rd_d = {13'h0000, bad_q, slo_q, shi_q, link.st_chan,
                          3'h0, link.st_state, link.cmd_ready, pend_q};
        default:  rd_d = '0;
      endcase
    end else begin
      rd_d = rd_q;
    end
  end

  // ----------
  // Registers
  // ----------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_q <= 1'b0;  shi_q <= 1'b0;  slo_q <= 1'b0;  bad_q <= 1'b0;
      op_q <= RCHS_OP_NONE;  hc_q <= 1'b0;  ch_q <= '0;  cal_q <= '0;
      prop_q <= '0;  data_q <= '0;  rd_q <= '0;
    end else if (i_ce) begin
      pend_q <= pend_d;  shi_q <= shi_d;  slo_q <= slo_d;  bad_q <= bad_d;
      op_q <= op_d;  hc_q <= hc_d;  ch_q <= ch_d;  cal_q <= cal_d;
      prop_q <= prop_d;  data_q <= data_d;  rd_q <= rd_d;
    end
  end

  // ----------
  // Outputs
  // ----------
  assign o_prdata          = rd_q;
  assign o_pready          = 1'b1;
  assign o_pslverr         = acc & !mapped;
  assign link.cmd_valid    = pend_q;
  assign link.cmd_op       = op_q;
  assign link.cmd_prop     = prop_q;
  assign link.cmd_data     = data_q;
  assign link.cmd_has_chan = hc_q;
  assign link.cmd_chan     = ch_q;
  assign link.cmd_calib    = cal_q;

endmodule // rchs_host

// ===== rchs_link_asserts.sv
// Checker on the command link between host and hop sequencer.
// Assumes i_ce held high and AUTO_HOP_CYCLES set to 40.
`timescale 1ns/1ps
module rchs_link_asserts
  import rchs_pkg::*;
(
  input wire logic                  i_mclk,
  input wire logic                  i_arst_n,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_ready,
  input wire rchs_pkg::rchs_op_t    cmd_op,
  input wire logic                  cmd_has_chan,
  input wire logic [7:0]            cmd_chan,
  input wire rchs_pkg::rchs_state_t st_state,
  input wire logic [7:0]            st_chan
);
  // ----------
  // Link properties
  // ----------
  localparam int HOP_MAX = 40;
  logic tk;
  assign tk = cmd_valid && cmd_ready;  // Command taken at this edge
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  property p_busy; st_state inside {RCHS_SEEK, RCHS_SETTLE, RCHS_TX_UP,
    RCHS_TX_DOWN} |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
    && $stable(cmd_chan); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_chan; tk && cmd_op == RCHS_OP_START_RX && cmd_has_chan
    |=> st_chan == $past(cmd_chan); endproperty
  a_chan: assert property (p_chan) else $error("start chan");
  property p_keep; tk && !cmd_has_chan && cmd_op inside {RCHS_OP_START_RX,
    RCHS_OP_START_TX} |=> $stable(st_chan); endproperty
  a_keep: assert property (p_keep) else $error("chan lost");
  property p_rx; tk && cmd_op == RCHS_OP_START_RX |=> st_state == RCHS_RX;
    endproperty
  a_rx: assert property (p_rx) else $error("no receive");
  property p_hop; $past(st_state) == RCHS_RX && st_state == RCHS_SEEK
    |-> ##[1:HOP_MAX] st_state == RCHS_RX; endproperty
  a_hop: assert property (p_hop) else $error("hop too slow");
  property p_skip; st_state == RCHS_SETTLE |-> st_chan != SKIP_ENTRY;
    endproperty
  a_skip: assert property (p_skip) else $error("skip entry used");
  property p_man; tk && cmd_op == RCHS_OP_RX_HOP |=> st_state == RCHS_SETTLE;
    endproperty
  a_man: assert property (p_man) else $error("no manual hop");
  property p_tx; tk && cmd_op == RCHS_OP_START_TX
    |=> st_state == RCHS_TX_UP; endproperty
  a_tx: assert property (p_tx) else $error("no ramp up");
endmodule  // rchs_link_asserts

// ===== rx_channel_hop_sequencer_test.sv
// Testbench: APB host end and device end joined by the command link.
// Assumes AUTO_HOP_CYCLES of 40 so that auto hops stay short.
`timescale 1ns/1ps
module rx_channel_hop_sequencer_test;
  import rchs_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        gpio, ramp, ext_ramp, ext_on, pa_on, tmo;
  logic [7:0]  paddr, rssi;
  logic [31:0] pwdata, prdata, rd, nramp, ndiff;
  logic [27:0] synth;
  logic [15:0] calib;
  logic [6:0]  fine;
  int          num_errors, n_compared, cyc;
  rchs_if rchs_if_inst();
  rchs_host rchs_host_inst(.i_mclk(clk), .i_arst_n(rst_n), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .link(rchs_if_inst));
  rchs_dev #(.AUTO_HOP_CYCLES(40)) rchs_dev_inst(.i_mclk(clk),
    .i_arst_n(rst_n), .i_ce(1'b1), .link(rchs_if_inst), .i_rssi(rssi),
    .i_preamble_timeout(tmo), .i_sync_timeout(tmo), .i_tx_mod(16'h0000),
    .o_synth_word(synth), .o_calib_count(calib), .o_hop_gpio(gpio),
    .o_pa_on(pa_on), .o_pa_ramping(ramp), .o_ext_ramp_on(ext_on),
    .o_ext_ramp_ramping(ext_ramp), .o_pwr_fine(fine), .o_pwr_coarse());
  rchs_link_asserts rchs_link_asserts_inst(.i_mclk(clk), .i_arst_n(rst_n),
    .cmd_valid(rchs_if_inst.cmd_valid), .cmd_ready(rchs_if_inst.cmd_ready),
    .cmd_op(rchs_if_inst.cmd_op), .cmd_has_chan(rchs_if_inst.cmd_has_chan),
    .cmd_chan(rchs_if_inst.cmd_chan), .st_state(rchs_if_inst.st_state),
    .st_chan(rchs_if_inst.st_chan));
  // ----------
  // Bus tasks and checking
  // ----------
  task automatic chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // One APB transfer; waits on pready rather than assuming no wait states
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Commands written while pending are dropped, so poll it clear
  task automatic run(input logic [31:0] w);
    apb(1'b1, A_CMD, w);
    do apb(1'b0, A_STATUS, 32'h00000000); while (rd[0] !== 1'b0);
  endtask
  task automatic setp(input logic [15:0] p, input logic [7:0] d);
    apb(1'b1, A_PROP, {8'h00, d, p});
    run(32'h00000001);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_freq();
    chk("init chan", rchs_if_inst.st_chan, CHAN_INIT);
    setp(P_FRAC_HIGH, 8'h00);
    apb(1'b0, A_STATUS, 32'h00000000);
    chk("refused", rd[18], 1'b1);
    apb(1'b1, A_STATUS, 32'h00000000);
    apb(1'b1, 8'h0C, 32'h00000000);
    chk("slverr", err, 1'b1);
    setp(P_INTE, 8'h20);
    setp(P_FRAC_HIGH, 8'h08);
    setp(P_FRAC_MID, 8'h12);
    setp(P_FRAC_LOW, 8'h34);
    setp(P_STEP_HIGH, 8'h01);
    setp(P_STEP_LOW, 8'h00);
    run(32'h0000050A);
    chk("synth", synth, (28'h20 << 19) + 28'h81234 + 5 * 28'h100);
    run(32'h00000005);
    run(32'h00000002);
    chk("kept chan", rchs_if_inst.st_chan, 8'h05);
    run(32'h00000005);
    $display("freq test done");
  endtask
  task automatic t_hop();
    logic [7:0]  prev, nxt;
    logic [31:0] hops, tog;
    logic        g;
    hops = 0;
    tog = 0;
    setp(P_HOP_SIZE, 8'h04);
    setp(P_HOP_ENTRY, 8'h03);
    setp(P_HOP_ENTRY + 16'h0001, SKIP_ENTRY);
    setp(P_HOP_ENTRY + 16'h0002, 8'h07);
    setp(P_HOP_ENTRY + 16'h0003, 8'h09);
    setp(P_RSSI_THR, 8'h80);
    setp(P_HOP_CTRL, 8'h19);
    g = gpio;
    run(32'h0000030A);
    prev = 8'h03;
    repeat (500) begin
      @(posedge clk);
      if (gpio !== g) tog++;
      g = gpio;
      if (rchs_if_inst.st_chan !== prev) begin
        nxt = (prev == 8'h03) ? 8'h07 : (prev == 8'h07) ? 8'h09 : 8'h03;
        chk("next chan", rchs_if_inst.st_chan, nxt);
        prev = rchs_if_inst.st_chan;
        hops++;
      end
    end
    chk("hops", hops > 5, 1'b1);
    chk("gpio", tog > 0, 1'b1);
    rssi <= 8'hF0;
    repeat (60) @(posedge clk);
    prev = rchs_if_inst.st_chan;
    repeat (100) @(posedge clk);
    chk("stay", rchs_if_inst.st_chan, prev);
    run({16'hABCD, 8'h02, 8'h0C});
    repeat (4000) if (rchs_if_inst.st_state !== RCHS_RX) @(posedge clk);
    chk("calib", calib, 16'hABCD);
    // Raw mode ignores timeouts; without raw they force a hop
    tmo <= 1'b1;
    setp(P_HOP_CTRL, 8'h2E);
    run(32'h0000030A);
    repeat (100) @(posedge clk);
    chk("raw stay", rchs_if_inst.st_chan, 8'h03);
    setp(P_HOP_CTRL, 8'h0E);
    repeat (10) @(posedge clk);
    chk("timeout hop", rchs_if_inst.st_chan, 8'h07);
    tmo <= 1'b0;
    run(32'h00000005);
    $display("hop test done");
  endtask
  // Ramp code 1 lasts 54 cycles, once up and once down
  task automatic t_tx();
    run(32'h00000003);
    repeat (60) @(posedge clk);
    chk("pa on", pa_on, 1'b1);
    chk("ext off", ext_on, 1'b0);
    run(32'h00000005);
    setp(P_AMP_TYPE, 8'h80);
    setp(P_RAMP_TIME, 8'h01);
    setp(P_PWR_FINE, 8'hFF);
    chk("fine", fine, PWR_FINE_MASK);
    nramp = 0;
    ndiff = 0;
    run(32'h00000003);
    repeat (100) @(posedge clk);
    run(32'h00000005);
    repeat (100) @(posedge clk);
    chk("ramp", nramp, 32'h0000006C);
    chk("ext ramp", ndiff, 32'h00000000);
    $display("tx test done");
  endtask
  // Clock, ramp counters and the hang limit
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (ramp === 1'b1) nramp++;
    if (ramp === 1'b1 && ext_ramp !== 1'b1) ndiff++;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    {psel, penable, pwrite, rst_n, tmo} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rssi = 8'h10;
    nramp = 32'h00000000;
    ndiff = 32'h00000000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_freq();
    t_hop();
    t_tx();
    report_and_stop();
  end
endmodule  // rx_channel_hop_sequencer_test
